// ### hw/main_timer_capture_compare_ctrl.sv
// Main timer core: counter, prescaler, capture and compare channels, flags.
`default_nettype none
`include "timer_core_cfg.svh"
module main_timer_capture_compare_ctrl (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire timer_core_pkg::reg_req_s   req_i,
   output logic [15:0]                     rdata_o,
   input  wire logic                       special_mode_n_i,
   input  wire logic                       wait_mode_i,
   input  wire logic                       debug_mode_i,
   input  wire logic [7:0]                 pin_i,
   input  wire logic [7:0]                 port_dir_i,
   output logic [7:0]                      pin_o,
   output logic [7:0]                      pin_oe_o,
   output logic                            timer_irq_o,
   output timer_core_pkg::side_out_s       side_o
);
   import timer_core_pkg::*;

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   sys_ctrl_s     sys_q;
   ovf_pre_ctrl_s ovf_ctrl_q;
   logic [7:0]    chan_dir_sel_q;
   logic [7:0]    ch7_mask_q;
   logic [15:0]   out_action_q;
   logic [15:0]   cap_edge_q;
   logic [7:0]    chan_irq_en_q;
   logic [7:0]    chan_flag_q;
   logic [7:0]    chan_flag_d;
   logic          overflow_flag_q;
   logic          overflow_flag_d;
   logic [15:0]   main_count_q;
   logic [15:0]   main_count_d;
   logic [6:0]    pre_q;
   logic [2:0]    pre_sel_q;
   logic [7:0]    pin_prev_q;
   logic [7:0]    out_level_q;
   logic [7:0]    out_level_d;
   logic [15:0]   rdata_q;
   logic [15:0]   chan_value [8];

   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------
   wire        acc      = req_i.wr | req_i.rd;
   wire        wr_cnt   = req_i.wr && req_i.addr == `ADDR_MAIN_COUNT;
   wire        acc_cnt  = acc && (req_i.addr == `ADDR_MAIN_COUNT
                                  || req_i.addr == `ADDR_MAIN_COUNT_B);
   wire        wr_cflg  = req_i.wr && req_i.addr == `ADDR_CHAN_FLAGS;
   wire        wr_oflg  = req_i.wr && req_i.addr == `ADDR_OVF_FLAGS;
   wire        in_chan  = req_i.addr[7:4] == `ADDR_CHAN_BASE >> 4;
   wire [2:0]  chan_idx = req_i.addr[3:1];
   wire [7:0]  wbyte    = req_i.wdata[7:0];

   // -------------------------------------------------------------------------
   // Run conditions and prescaler
   // -------------------------------------------------------------------------
   // Wait stop halts all counting, masks the interrupt and raises both side stops; debug stop also halts acc_tick but leaves acc_stop low.
   wire wait_stop  = sys_q.stop_in_wait & wait_mode_i;
   wire debug_stop = sys_q.stop_in_debug & debug_mode_i;
   wire running    = sys_q.timer_enable & ~wait_stop & ~debug_stop;

   wire [6:0] pre_mask = 7'(({1'b0, 7'h7F} << pre_sel_q) >> 1) ^ 7'h00;
   wire [6:0] stage_mask = ~(7'h7F << pre_sel_q);
   wire       tick = running && ((pre_q & stage_mask) == stage_mask);
   wire       pre_zero = pre_q == 7'h00;

   // The selection is only loaded at a zero phase, so a mid-period change
   // never produces a runt tick.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_q     <= 7'h00;
         pre_sel_q <= 3'h0;
      end else begin
         if (running) begin
            pre_q <= pre_q + 7'h01;
         end
         if (pre_zero) begin
            pre_sel_q <= ovf_ctrl_q.prescale_sel;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Main counter
   // -------------------------------------------------------------------------
   // The channel 7 match is seen on the tick that leaves its value.
   wire ch7_match = tick && chan_dir_sel_q[7] && main_count_q == chan_value[7];
   wire cnt_clear = ovf_ctrl_q.clear_on_ch7_match & ch7_match;
   wire wrap      = tick && !cnt_clear && main_count_q == `COUNT_ALL_ONES;

   // Software writes do not touch the prescaler phase.
   always_comb begin
      main_count_d = main_count_q;
      if (cnt_clear) begin
         main_count_d = `RST_WORD;
      end else if (tick) begin
         main_count_d = main_count_q + 16'h0001;
      end
      if (wr_cnt && !special_mode_n_i) begin
         main_count_d = req_i.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         main_count_q <= `RST_WORD;
      end else begin
         main_count_q <= main_count_d;
      end
   end

   // -------------------------------------------------------------------------
   // Channels
   // -------------------------------------------------------------------------
   logic [7:0] chan_set;
   logic [7:0] chan_fast_clr;

   for (genvar g = 0; g < 8; g++) begin : g_chan
      logic [15:0] value_q;
      wire [1:0] act  = out_action_q[2*g+1 -: 2];
      wire [1:0] edg  = cap_edge_q[2*g+1 -: 2];
      wire rise       = pin_i[g] & ~pin_prev_q[g];
      wire fall       = ~pin_i[g] & pin_prev_q[g];
      wire cap_hit    = ~chan_dir_sel_q[g]
                        & ((edg[0] & rise) | (edg[1] & fall));
      wire cmp_hit    = tick & chan_dir_sel_q[g] & (main_count_q == value_q);
      wire sel        = in_chan && chan_idx == 3'(g);
      wire cmp_wr     = req_i.wr & sel & chan_dir_sel_q[g];

      // Writes in capture mode are dropped; captures take the live count.
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            value_q <= `RST_WORD;
         end else if (cap_hit) begin
            value_q <= main_count_q;
         end else if (cmp_wr) begin
            value_q <= req_i.wdata;
         end
      end

      assign chan_value[g]    = value_q;
      assign chan_set[g]      = cap_hit | cmp_hit;
      assign chan_fast_clr[g] = sys_q.fast_flag_clear
                                & ((req_i.rd & sel & ~chan_dir_sel_q[g])
                                   | cmp_wr);

      // The mask bit blocks the action from reaching the pin.
      always_comb begin
         out_level_d[g] = out_level_q[g];
         if (cmp_hit && !ch7_mask_q[g]) begin
            unique case (act)
               2'b00: out_level_d[g] = out_level_q[g];
               2'b01: out_level_d[g] = ~out_level_q[g];
               2'b10: out_level_d[g] = 1'b0;
               2'b11: out_level_d[g] = 1'b1;
            endcase
         end
      end

      assign pin_oe_o[g] = (act != 2'b00) ? 1'b1 : port_dir_i[g];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_prev_q  <= `RST_BYTE;
         out_level_q <= `RST_BYTE;
      end else begin
         pin_prev_q  <= pin_i;
         out_level_q <= out_level_d;
      end
   end

   assign pin_o = out_level_q;

   // -------------------------------------------------------------------------
   // Flags
   // -------------------------------------------------------------------------
   // A set in the same cycle as a clear wins, so no event is lost.
   always_comb begin
      chan_flag_d = chan_flag_q & ~chan_fast_clr;
      if (wr_cflg) begin
         chan_flag_d = chan_flag_d & ~wbyte;
      end
      chan_flag_d = chan_flag_d | chan_set;
      overflow_flag_d = overflow_flag_q;
      if ((wr_oflg && wbyte[`OVF_FLAG_BIT])
          || (acc_cnt && sys_q.fast_flag_clear)) begin
         overflow_flag_d = 1'b0;
      end
      if (wrap) begin
         overflow_flag_d = 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_q           <= sys_ctrl_s'(`RST_BYTE);
         ovf_ctrl_q      <= ovf_pre_ctrl_s'(`RST_BYTE);
         chan_dir_sel_q  <= `RST_BYTE;
         ch7_mask_q      <= `RST_BYTE;
         out_action_q    <= `RST_WORD;
         cap_edge_q      <= `RST_WORD;
         chan_irq_en_q   <= `RST_BYTE;
         chan_flag_q     <= `RST_BYTE;
         overflow_flag_q <= 1'b0;
      end else begin
         chan_flag_q     <= chan_flag_d;
         overflow_flag_q <= overflow_flag_d;
         if (req_i.wr) begin
            unique case (req_i.addr)
               `ADDR_SYS_CTRL:     sys_q              <= sys_ctrl_s'(wbyte);
               `ADDR_OVF_PRE_CTRL: ovf_ctrl_q         <= ovf_pre_ctrl_s'(wbyte);
               `ADDR_CHAN_DIR:     chan_dir_sel_q     <= wbyte;
               `ADDR_CH7_MASK:     ch7_mask_q         <= wbyte;
               `ADDR_OUT_ACT_HI:   out_action_q[15:8] <= wbyte;
               `ADDR_OUT_ACT_LO:   out_action_q[7:0]  <= wbyte;
               `ADDR_CAP_EDGE_HI:  cap_edge_q[15:8]   <= wbyte;
               `ADDR_CAP_EDGE_LO:  cap_edge_q[7:0]    <= wbyte;
               `ADDR_CHAN_IRQ_EN:  chan_irq_en_q      <= wbyte;
               default:            ;
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------------
   // The counter word is taken whole in one cycle, so both bytes agree.
   logic [15:0] rd_word;
   always_comb begin
      rd_word = `RST_WORD;
      if (in_chan) begin
         rd_word = chan_value[chan_idx];
      end else begin
         unique case (req_i.addr)
            `ADDR_MAIN_COUNT:   rd_word = main_count_q;
            `ADDR_SYS_CTRL:     rd_word = {8'h00, sys_q};
            `ADDR_OVF_PRE_CTRL: rd_word = {8'h00, ovf_ctrl_q};
            `ADDR_CHAN_DIR:     rd_word = {8'h00, chan_dir_sel_q};
            `ADDR_CH7_MASK:     rd_word = {8'h00, ch7_mask_q};
            `ADDR_OUT_ACT_HI:   rd_word = {8'h00, out_action_q[15:8]};
            `ADDR_OUT_ACT_LO:   rd_word = {8'h00, out_action_q[7:0]};
            `ADDR_CAP_EDGE_HI:  rd_word = {8'h00, cap_edge_q[15:8]};
            `ADDR_CAP_EDGE_LO:  rd_word = {8'h00, cap_edge_q[7:0]};
            `ADDR_CHAN_IRQ_EN:  rd_word = {8'h00, chan_irq_en_q};
            `ADDR_CHAN_FLAGS:   rd_word = {8'h00, chan_flag_q};
            `ADDR_OVF_FLAGS:    rd_word = {8'h00, overflow_flag_q, 7'h00};
            default:            rd_word = `RST_WORD;
         endcase
      end
   end

   // Read data stand for exactly one cycle after the strobe.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= `RST_WORD;
      end else begin
         rdata_q <= req_i.rd ? rd_word : `RST_WORD;
      end
   end

   assign rdata_o = rdata_q;

   // -------------------------------------------------------------------------
   // Interrupt and side-band outputs
   // -------------------------------------------------------------------------
   // A frozen timer in wait must not be able to wake the processor.
   wire chan_req = |(chan_flag_q & chan_irq_en_q);
   wire ovf_req  = overflow_flag_q & ovf_ctrl_q.overflow_irq_en;
   assign timer_irq_o = (chan_req | ovf_req) & ~wait_stop;

   wire acc_a_hit = acc && (req_i.addr == `ADDR_ACC_A_HI
                            || req_i.addr == `ADDR_ACC_A_LO);
   wire acc_b_hit = acc && (req_i.addr == `ADDR_ACC_B_HI
                            || req_i.addr == `ADDR_ACC_B_LO);

   assign side_o.acc_tick       = running
                                  && pre_q[`ACC_TICK_STAGES-1:0] == 6'h3F;
   assign side_o.acc_stop       = wait_stop;
   assign side_o.modcnt_stop    = wait_stop | debug_stop;
   assign side_o.acc_a_flag_clr = sys_q.fast_flag_clear & acc_a_hit;
   assign side_o.acc_b_flag_clr = sys_q.fast_flag_clear & acc_b_hit;

   wire unused_ok = ^{pre_mask, ovf_ctrl_q.spare_6, sys_q.unused};

endmodule
`default_nettype wire

// ### hw/timer_core_cfg.svh
// Offsets, field positions, reset values and timing counts of the timer core.
`ifndef TIMER_CORE_CFG_SVH
`define TIMER_CORE_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_CHAN_DIR     8'h80
`define ADDR_CH7_MASK     8'h82
`define ADDR_MAIN_COUNT   8'h84
`define ADDR_MAIN_COUNT_B 8'h85
`define ADDR_SYS_CTRL     8'h86
`define ADDR_OUT_ACT_HI   8'h88
`define ADDR_OUT_ACT_LO   8'h89
`define ADDR_CAP_EDGE_HI  8'h8A
`define ADDR_CAP_EDGE_LO  8'h8B
`define ADDR_CHAN_IRQ_EN  8'h8C
`define ADDR_OVF_PRE_CTRL 8'h8D
`define ADDR_CHAN_FLAGS   8'h8E
`define ADDR_OVF_FLAGS    8'h8F
`define ADDR_CHAN_BASE    8'h90
`define ADDR_ACC_A_HI     8'hA2
`define ADDR_ACC_A_LO     8'hA3
`define ADDR_ACC_B_HI     8'hA4
`define ADDR_ACC_B_LO     8'hA5

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define OVF_FLAG_BIT      7
`define RST_BYTE          8'h00
`define RST_WORD          16'h0000
`define COUNT_ALL_ONES    16'hFFFF

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define PRE_STAGES        7
`define ACC_TICK_STAGES   6

`endif

// ### hw/timer_core_pkg.sv
// Types shared by the timer core and its users.
`default_nettype none
package timer_core_pkg;

   // System control byte, most significant field first.
   typedef struct packed {
      logic       timer_enable;
      logic       stop_in_wait;
      logic       stop_in_debug;
      logic       fast_flag_clear;
      logic [3:0] unused;
   } sys_ctrl_s;

   // Overflow interrupt and prescaler control byte.
   typedef struct packed {
      logic       overflow_irq_en;
      logic       spare_6;
      logic       pullup_en;
      logic       drive_reduce;
      logic       clear_on_ch7_match;
      logic [2:0] prescale_sel;
   } ovf_pre_ctrl_s;

   // Register port request from software.
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

   // Side-band outputs toward the accumulator and modulus counter blocks.
   typedef struct packed {
      logic acc_tick;
      logic acc_stop;
      logic modcnt_stop;
      logic acc_a_flag_clr;
      logic acc_b_flag_clr;
   } side_out_s;

endpackage
`default_nettype wire

// ### test/timer_core_monitor.sv
// Port checker for the main timer core, bound into every instance of it.
`default_nettype none
module timer_core_monitor
   import timer_core_pkg::*;
(
   input wire logic                      clk_i,
   input wire logic                      rst_i,
   input wire timer_core_pkg::reg_req_s  req_i,
   input wire logic [15:0]               rdata_o,
   input wire logic                      special_mode_n_i,
   input wire logic                      wait_mode_i,
   input wire logic                      debug_mode_i,
   input wire logic [7:0]                pin_i,
   input wire logic [7:0]                port_dir_i,
   input wire logic [7:0]                pin_o,
   input wire logic [7:0]                pin_oe_o,
   input wire logic                      timer_irq_o,
   input wire timer_core_pkg::side_out_s side_o
);
   // ---------------------------------------------------------------
   // Shadows
   // ---------------------------------------------------------------
   logic [7:0]  sys_q;
   logic [7:0]  ovf_q;
   logic [7:0]  irq_en_q;
   logic [15:0] act_q;
   logic [7:0]  act_nz;
   logic        wait_stop;
   logic        dbg_stop;
   logic        any_acc;
   // Control bytes follow software writes on the same edge as the core does.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_q    <= 8'h00;
         ovf_q    <= 8'h00;
         irq_en_q <= 8'h00;
         act_q    <= 16'h0000;
      end else if (req_i.wr) begin
         if (req_i.addr == 8'h86) sys_q <= req_i.wdata[7:0];
         if (req_i.addr == 8'h8D) ovf_q <= req_i.wdata[7:0];
         if (req_i.addr == 8'h8C) irq_en_q <= req_i.wdata[7:0];
         if (req_i.addr == 8'h88) act_q[15:8] <= req_i.wdata[7:0];
         if (req_i.addr == 8'h89) act_q[7:0] <= req_i.wdata[7:0];
      end
   end
   // A nonzero output field claims its pin whatever the direction bit says.
   always_comb begin
      for (int i = 0; i < 8; i++) act_nz[i] = |act_q[2*i +: 2];
   end
   assign wait_stop = sys_q[6] && wait_mode_i;
   assign dbg_stop  = sys_q[5] && debug_mode_i;
   assign any_acc   = sys_q[4] && (req_i.wr || req_i.rd);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_tick_when_run: assert property (side_o.acc_tick |-> (sys_q[7] && !wait_stop) ##1 !side_o.acc_tick)
      else $error("divide-by-64 tick while timer idle or too close");
   a_acc_stop_lvl: assert property (side_o.acc_stop == wait_stop)
      else $error("accumulator stop does not follow wait stop");
   a_mod_stop_lvl: assert property (side_o.modcnt_stop == (wait_stop || dbg_stop))
      else $error("modulus stop does not follow wait or debug stop");
   a_irq_wait_mask: assert property (wait_stop |-> !timer_irq_o)
      else $error("interrupt raised while stopped in wait");
   a_irq_needs_en: assert property (timer_irq_o |-> ovf_q[7] || (irq_en_q != 8'h00))
      else $error("interrupt raised with every enable clear");
   a_oe_forced: assert property (pin_oe_o == (act_nz | port_dir_i))
      else $error("pin enable does not follow output field");
   a_acc_a_clear: assert property (side_o.acc_a_flag_clr == (any_acc && req_i.addr[7:1] == 7'h51))
      else $error("accumulator A clear pulse wrong");
   a_acc_b_clear: assert property (side_o.acc_b_flag_clr == (any_acc && req_i.addr[7:1] == 7'h52))
      else $error("accumulator B clear pulse wrong");
   a_pin_idle_hold: assert property ((act_nz == 8'h00) ##1 (act_nz == 8'h00) |-> $stable(pin_o))
      else $error("compare pin moved with every field disconnected");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> rdata_o == 16'h0000 && pin_o == 8'h00)
      else $error("outputs not cleared by reset");
   c_tick: cover property (side_o.acc_tick);
   c_irq: cover property (timer_irq_o);
   c_acc_clr: cover property (side_o.acc_a_flag_clr);
endmodule
bind main_timer_capture_compare_ctrl timer_core_monitor u_timer_core_monitor (
   .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
   .special_mode_n_i(special_mode_n_i), .wait_mode_i(wait_mode_i), .debug_mode_i(debug_mode_i),
   .pin_i(pin_i), .port_dir_i(port_dir_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
   .timer_irq_o(timer_irq_o), .side_o(side_o));
`default_nettype wire

// ### test/timer_pin_model.sv
// Model of the timer port pins seen from outside the timer core.
`default_nettype none
module timer_pin_model (
   input  wire logic       clk_i,
   input  wire logic       slow_i,
   input  wire logic [7:0] level_i,
   input  wire logic [7:0] pin_o,
   input  wire logic [7:0] pin_oe_o,
   output logic      [7:0] pin_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] late_q;
   // A slow source shows a new level one clock late, which stresses capture timing.
   always_ff @(posedge clk_i) late_q <= level_i;
   // Pins the core drives read back its level; the others follow the source.
   assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & (slow_i ? late_q : level_i));
endmodule
`default_nettype wire

// ### test/main_timer_capture_compare_ctrl_test.sv
// Self-checking testbench for the main timer core.
`default_nettype none
module main_timer_capture_compare_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   import timer_core_pkg::*;
   logic        clk_i, rst_i, smode_n, wait_m, dbg_m, slow, irq, ep;
   reg_req_s    req;
   side_out_s   side;
   logic [15:0] rdata, v, w;
   logic [7:0]  pin_i, pin_o, pin_oe, port_dir, lvl;
   int          err_count, total_checks, ticks;
   logic [7:0]  ra [9] = '{8'h84, 8'h86, 8'h88, 8'h8A, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'hC0};
   main_timer_capture_compare_ctrl u_main_timer_capture_compare_ctrl (
      .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata), .special_mode_n_i(smode_n),
      .wait_mode_i(wait_m), .debug_mode_i(dbg_m), .pin_i(pin_i), .port_dir_i(port_dir),
      .pin_o(pin_o), .pin_oe_o(pin_oe), .timer_irq_o(irq), .side_o(side));
   timer_pin_model u_timer_pin_model (.clk_i(clk_i), .slow_i(slow), .level_i(lvl),
      .pin_o(pin_o), .pin_oe_o(pin_oe), .pin_i(pin_i));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Both strobes are one cycle; the #1 lets the taking edge settle.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_i);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk(d, e);
   endtask
   // Runs the counter for about ten ticks from a known start, then stops it.
   task automatic run_from(input logic [15:0] start);
      wr(8'h84, start);
      wr(8'h86, 16'h0080);
      repeat (8) @(posedge clk_i);
      wr(8'h86, 16'h0000);
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // A hang is cut short here and counted as a mismatch.
   initial begin
      #1ms;
      err_count++;
      give_verdict();
   end
   always @(posedge clk_i) if (side.acc_tick === 1'b1) ticks <= ticks + 1;
   initial begin
      rst_i = 1'b1;
      smode_n = 1'b1;
      req = '0;
      {wait_m, dbg_m, slow, lvl} = '0;
      port_dir = 8'hA0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ra[i]) rc(ra[i], 16'h0000);
      wr(8'h84, 16'h1234);
      rc(8'h84, 16'h0000);
      smode_n <= 1'b0;
      wr(8'h84, 16'h1234);
      repeat (20) @(posedge clk_i);
      rc(8'h84, 16'h1234);
      wr(8'h86, 16'h0080);
      for (int s = 0; s < 8; s++) begin
         wr(8'h8D, 16'(s));
         repeat (300) @(posedge clk_i);
         rd(8'h84, v);
         repeat ((10 << s) - 2) @(posedge clk_i);
         rd(8'h84, w);
         chk(w - v, 16'h000A);
      end
      for (int en = 1; en >= 0; en--) begin
         wr(8'h86, 16'(en << 7));
         rd(8'h84, v);
         ticks = 0;
         repeat (640) @(posedge clk_i);
         #1 chk(16'(ticks), 16'(10 * en));
      end
      rc(8'h84, v);
      wr(8'h8D, 16'h0080);
      run_from(16'hFFF0);
      wr(8'h86, 16'h0080);
      repeat (150) @(posedge clk_i);
      rc(8'h8F, 16'h0080);
      chk(16'(irq), 16'h0001);
      wr(8'h8F, 16'h0000);
      rc(8'h8F, 16'h0080);
      wr(8'h8D, 16'h0000);
      chk(16'(irq), 16'h0000);
      wr(8'h8F, 16'h0080);
      rc(8'h8F, 16'h0000);
      wr(8'h84, 16'hFFF0);
      wr(8'h86, 16'h0090);
      repeat (30) @(posedge clk_i);
      rc(8'h8F, 16'h0080);
      rd(8'h84, v);
      rc(8'h8F, 16'h0000);
      rd(8'hA2, v);
      rd(8'hA4, v);
      wr(8'h86, 16'h0000);
      wr(8'h82, 16'h0000);
      wr(8'h80, 16'h0081);
      wr(8'h9E, 16'h0010);
      wr(8'h90, 16'h0005);
      wr(8'h8D, 16'h0008);
      ep = 1'b0;
      for (int c = 3; c >= 0; c--) begin
         wr(8'h89, 16'(c));
         run_from(16'h0003);
         ep = (c == 3) ? 1'b1 : (c == 2) ? 1'b0 : (c == 1) ? !ep : ep;
         chk(16'(pin_o[0]), 16'(ep));
         chk(16'(pin_oe[0]), 16'(c != 0));
      end
      rc(8'h8E, 16'h0001);
      chk(16'(irq), 16'h0000);
      wr(8'h8C, 16'h0001);
      chk(16'(irq), 16'h0001);
      wr(8'h8E, 16'h0000);
      rc(8'h8E, 16'h0001);
      wr(8'h8E, 16'h0001);
      rc(8'h8E, 16'h0000);
      run_from(16'h0003);
      wr(8'h86, 16'h0010);
      wr(8'h90, 16'h0005);
      rc(8'h8E, 16'h0000);
      wr(8'h9E, 16'h0000);
      run_from(16'h0000);
      rc(8'h84, 16'h0000);
      wr(8'h9E, 16'h0010);
      run_from(16'h000C);
      rd(8'h84, v);
      chk(16'(v < 16'h000C), 16'h0001);
      wr(8'h8D, 16'h0000);
      wr(8'h86, 16'h0080);
      slow = 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(8'h8B, 16'(c << 2));
         for (int e = 0; e < 2; e++) begin
            wr(8'h8E, 16'h00FF);
            lvl[1] <= (e == 0);
            repeat (4) @(posedge clk_i);
            rd(8'h8E, v);
            chk(16'(v[1]), 16'((c >> e) & 1));
         end
      end
      wr(8'h8C, 16'h00FF);
      wr(8'h86, 16'h00E0);
      for (int m = 0; m < 2; m++) begin
         {wait_m, dbg_m} <= (m == 0) ? 2'b10 : 2'b01;
         rd(8'h84, v);
         repeat (20) @(posedge clk_i);
         rc(8'h84, v);
         chk(16'(irq), 16'(m));
      end
      {wait_m, dbg_m} <= 2'b10;
      wr(8'h86, 16'h0090);
      rd(8'h84, v);
      repeat (18) @(posedge clk_i);
      rd(8'h84, w);
      chk(w - v, 16'h0014);
      wait_m <= 1'b0;
      lvl[1] <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(8'h92, v);
      rd(8'h8E, v);
      chk(16'(v[1]), 16'h0000);
      give_verdict();
   end
endmodule
`default_nettype wire
